/* design/stc_regs.svh */
`ifndef STC_REGS_SVH
`define STC_REGS_SVH

// register addresses in the special-function space
`define STC_ADDR_TCTL      8'h88
`define STC_ADDR_TMODE     8'h89
`define STC_ADDR_TL0       8'h8a
`define STC_ADDR_TL1       8'h8b
`define STC_ADDR_TH0       8'h8c
`define STC_ADDR_TH1       8'h8d
`define STC_ADDR_T2CTL     8'hc8
`define STC_ADDR_RCL2      8'hca
`define STC_ADDR_RCH2      8'hcb
`define STC_ADDR_TL2       8'hcc
`define STC_ADDR_TH2       8'hcd

// shared control field positions
`define STC_TCTL_TF1       7
`define STC_TCTL_TR1       6
`define STC_TCTL_TF0       5
`define STC_TCTL_TR0       4

// timer 2 control field positions
`define STC_T2_TF2         7
`define STC_T2_CAPTURE     3
`define STC_T2_TR2         2
`define STC_T2_CT2         1
`define STC_T2_NORELOAD    0

// reset values
`define STC_TCTL_RST       8'h00
`define STC_TMODE_RST      8'h00
`define STC_T2CTL_RST      8'h00
`define STC_CNT_RST        8'h00

// timing: oscillator periods per timer tick and per undivided sample
`define STC_OSC_PER_TICK   12
`define STC_PRESCALE_MAX   4'(`STC_OSC_PER_TICK - 1)

`endif

/* design/stc_pkg.sv */
package stc_pkg;

    typedef enum logic [1:0] {
        STC_MODE_13BIT  = 2'b00,
        STC_MODE_16BIT  = 2'b01,
        STC_MODE_RELOAD = 2'b10,
        STC_MODE_SPLIT  = 2'b11
    } stc_mode_e;

    // one nibble of the shared mode register
    typedef struct packed {
        logic      gate;
        logic      counter_sel;
        stc_mode_e mode;
    } stc_tmode_s;

    // result of one count step
    typedef struct packed {
        logic [7:0] hi;
        logic [7:0] lo;
        logic       ovf;
    } stc_step_s;

endpackage

/* design/stc_tick_gen.sv */
`timescale 1ns/1ns
`include "stc_regs.svh"

module stc_tick_gen
    import stc_pkg::*;
(
    input  logic       ref_clk,
    input  logic       rst,
    input  logic [2:0] cpu_div,
    output logic       tick,
    output logic       sample_en
);

    logic [3:0] prescale;
    logic [6:0] div_cnt;
    wire        wrap     = (prescale == `STC_PRESCALE_MAX);
    wire  [6:0] div_mask = 7'h7f >> (3'd7 - cpu_div);
    wire        div_done = ((div_cnt & div_mask) == div_mask);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prescale  <= 4'h0;
            div_cnt   <= 7'h00;
            tick      <= 1'b0;
            sample_en <= 1'b0;
        end else begin
            prescale  <= wrap ? 4'h0 : prescale + 4'h1;
            div_cnt   <= wrap ? div_cnt + 7'h01 : div_cnt;
            tick      <= wrap;
            sample_en <= wrap & div_done;
        end
    end

endmodule

/* design/stc_pin_sampler.sv */
`timescale 1ns/1ns

module stc_pin_sampler
    import stc_pkg::*;
(
    input  logic ref_clk,
    input  logic rst,
    input  logic sample_en,
    input  logic pin,
    output logic level,
    output logic count_pulse
);

    logic meta;
    logic prev_sample;
    logic last_sample;

    assign count_pulse = sample_en & prev_sample & ~last_sample;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            meta        <= 1'b0;
            level       <= 1'b0;
            prev_sample <= 1'b0;
            last_sample <= 1'b0;
        end else begin
            meta  <= pin;
            level <= meta;
            if (sample_en) begin
                prev_sample <= last_sample;
                last_sample <= level;
            end
        end
    end

endmodule

/* design/stc_top.sv */
`timescale 1ns/1ns
`include "stc_regs.svh"

module stc_top
    import stc_pkg::*;
(
    input  logic       ref_clk,
    input  logic       rst,
    input  logic [7:0] sfr_addr,
    input  logic       sfr_wr,
    input  logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input  logic [2:0] cpu_clock_divider_config,
    input  logic       timer_zero_event_pin,
    input  logic       timer_one_event_pin,
    input  logic       timer_two_event_pin,
    input  logic [1:0] external_interrupt_pin,
    input  logic [2:0] overflow_ack,
    output logic [2:0] timer_overflow_flag
);

    logic       tick;
    logic       sample_en;
    logic [2:0] ev_pulse;
    logic [1:0] int_level;
    logic [2:0] ev_level_unused;
    logic [1:0] int_pulse_unused;

    logic [7:0] timer_shared_control;
    logic [7:0] timer_shared_mode;
    logic [7:0] timer2_control;
    logic [7:0] timer0_count_low;
    logic [7:0] timer0_count_high;
    logic [7:0] timer1_count_low;
    logic [7:0] timer1_count_high;
    logic [7:0] timer2_count_low;
    logic [7:0] timer2_count_high;
    logic [7:0] timer2_capture_reload_low;
    logic [7:0] timer2_capture_reload_high;

    stc_tick_gen u_tick (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .cpu_div   (cpu_clock_divider_config),
        .tick      (tick),
        .sample_en (sample_en)
    );

    wire [2:0] ev_pins  = {timer_two_event_pin, timer_one_event_pin, timer_zero_event_pin};

    stc_pin_sampler u_ev0 (
        .ref_clk     (ref_clk),
        .rst         (rst),
        .sample_en   (sample_en),
        .pin         (ev_pins[0]),
        .level       (ev_level_unused[0]),
        .count_pulse (ev_pulse[0])
    );

    stc_pin_sampler u_ev1 (
        .ref_clk     (ref_clk),
        .rst         (rst),
        .sample_en   (sample_en),
        .pin         (ev_pins[1]),
        .level       (ev_level_unused[1]),
        .count_pulse (ev_pulse[1])
    );

    stc_pin_sampler u_ev2 (
        .ref_clk     (ref_clk),
        .rst         (rst),
        .sample_en   (sample_en),
        .pin         (ev_pins[2]),
        .level       (ev_level_unused[2]),
        .count_pulse (ev_pulse[2])
    );

    // gate pins, synchronised level only
    stc_pin_sampler u_int0 (
        .ref_clk     (ref_clk),
        .rst         (rst),
        .sample_en   (sample_en),
        .pin         (external_interrupt_pin[0]),
        .level       (int_level[0]),
        .count_pulse (int_pulse_unused[0])
    );

    stc_pin_sampler u_int1 (
        .ref_clk     (ref_clk),
        .rst         (rst),
        .sample_en   (sample_en),
        .pin         (external_interrupt_pin[1]),
        .level       (int_level[1]),
        .count_pulse (int_pulse_unused[1])
    );

    // one count step of a timer 0/1 byte pair
    function automatic stc_step_s step_pair(
        input logic [7:0] hi,
        input logic [7:0] lo,
        input stc_mode_e  mode,
        input logic       inc
    );
        stc_step_s r;
        r = '{hi: hi, lo: lo, ovf: 1'b0};
        if (inc) begin
            case (mode)
                STC_MODE_13BIT: begin
                    r.lo[4:0] = lo[4:0] + 5'h01;
                    if (lo[4:0] == 5'h1f) begin
                        r.hi  = hi + 8'h01;
                        r.ovf = (hi == 8'hff);
                    end
                end
                STC_MODE_16BIT: begin
                    {r.hi, r.lo} = {hi, lo} + 16'h0001;
                    r.ovf        = ({hi, lo} == 16'hffff);
                end
                // high byte holds the reload value
                STC_MODE_RELOAD: begin
                    r.lo  = (lo == 8'hff) ? hi : lo + 8'h01;
                    r.ovf = (lo == 8'hff);
                end
                STC_MODE_SPLIT: begin
                    r.lo  = lo + 8'h01;
                    r.ovf = (lo == 8'hff);
                end
                default: begin
                    r.ovf = 1'b0;
                end
            endcase
        end
        return r;
    endfunction

    // shared mode register split into two nibbles
    wire stc_tmode_s t0_mode = timer_shared_mode[3:0];
    wire stc_tmode_s t1_mode = timer_shared_mode[7:4];
    wire             run0    = timer_shared_control[`STC_TCTL_TR0];
    wire             run1    = timer_shared_control[`STC_TCTL_TR1];
    wire             run2    = timer2_control[`STC_T2_TR2];
    wire             split0  = (t0_mode.mode == STC_MODE_SPLIT);

    // timer or counter source per timer
    wire src0 = t0_mode.counter_sel ? ev_pulse[0] : tick;
    wire src1 = t1_mode.counter_sel ? ev_pulse[1] : tick;
    wire src2 = timer2_control[`STC_T2_CT2] ? ev_pulse[2] : tick;

    // run and gate qualify timers zero and one
    wire en0  = run0 & (~t0_mode.gate | int_level[0]);
    wire en1  = run1 & (~t1_mode.gate | int_level[1]);

    // timer 1 holds in its own split mode
    wire inc0 = en0 & src0;
    wire inc1 = en1 & src1 & (t1_mode.mode != STC_MODE_SPLIT) & ~split0;
    wire run1_free_ok = ~t1_mode.gate | int_level[1];
    wire inc1_free = src1 & (t1_mode.mode != STC_MODE_SPLIT) & split0 & run1_free_ok;
    wire inc2 = run2 & src2;

    wire stc_step_s step0 = step_pair(timer0_count_high, timer0_count_low,
                                      t0_mode.mode, inc0);
    wire stc_step_s step1 = step_pair(timer1_count_high, timer1_count_low,
                                      t1_mode.mode, inc1 | inc1_free);

    // split mode: high byte of timer 0 is a timer on the timer 1 run bit
    wire       th0_inc  = split0 & run1 & tick;
    wire [7:0] th0_next = split0 ? (th0_inc ? timer0_count_high + 8'h01 : timer0_count_high)
                                 : step0.hi;
    wire       th0_ovf  = th0_inc & (timer0_count_high == 8'hff);

    // timer 2: 16-bit count, reload from the capture/reload pair
    wire        t2_full   = ({timer2_count_high, timer2_count_low} == 16'hffff);
    wire        ovf2      = inc2 & t2_full;
    wire        no_reload = timer2_control[`STC_T2_NORELOAD];
    wire [15:0] t2_plus   = {timer2_count_high, timer2_count_low} + 16'h0001;
    wire [15:0] t2_reload = {timer2_capture_reload_high, timer2_capture_reload_low};
    wire [15:0] t2_next   = ~inc2 ? {timer2_count_high, timer2_count_low}
                          : (t2_full & ~no_reload) ? t2_reload : t2_plus;

    // overflow events, flag 1 taken by timer 0 high byte in split mode
    wire ovf0_evt = step0.ovf;
    wire ovf1_evt = split0 ? th0_ovf : step1.ovf & ~inc1_free;

    // register write decode
    wire wr_tctl  = sfr_wr & (sfr_addr == `STC_ADDR_TCTL);
    wire wr_tmode = sfr_wr & (sfr_addr == `STC_ADDR_TMODE);
    wire wr_t2ctl = sfr_wr & (sfr_addr == `STC_ADDR_T2CTL);
    wire wr_tl0   = sfr_wr & (sfr_addr == `STC_ADDR_TL0);
    wire wr_th0   = sfr_wr & (sfr_addr == `STC_ADDR_TH0);
    wire wr_tl1   = sfr_wr & (sfr_addr == `STC_ADDR_TL1);
    wire wr_th1   = sfr_wr & (sfr_addr == `STC_ADDR_TH1);
    wire wr_tl2   = sfr_wr & (sfr_addr == `STC_ADDR_TL2);
    wire wr_th2   = sfr_wr & (sfr_addr == `STC_ADDR_TH2);
    wire wr_rcl2  = sfr_wr & (sfr_addr == `STC_ADDR_RCL2);
    wire wr_rch2  = sfr_wr & (sfr_addr == `STC_ADDR_RCH2);

    // software capture strobe copies the running count
    wire capture2 = wr_t2ctl & sfr_wdata[`STC_T2_CAPTURE];

    wire [2:0] ovf_evt   = {ovf2, ovf1_evt, ovf0_evt};
    wire [2:0] next_flag = ovf_evt | (timer_overflow_flag & ~overflow_ack);

    // software writes run bits, plus counter select and no-reload in timer 2 control; flag bits are read-only
    wire [7:0] tctl_wmask = (8'h01 << `STC_TCTL_TR1) | (8'h01 << `STC_TCTL_TR0);
    wire [7:0] t2_wmask   = (8'h01 << `STC_T2_TR2) | (8'h01 << `STC_T2_CT2)
                          | (8'h01 << `STC_T2_NORELOAD);

    logic [7:0] tctl_rd;
    logic [7:0] t2ctl_rd;
    always_comb begin
        tctl_rd                   = timer_shared_control & tctl_wmask;
        tctl_rd[`STC_TCTL_TF1]    = timer_overflow_flag[1];
        tctl_rd[`STC_TCTL_TF0]    = timer_overflow_flag[0];
        t2ctl_rd                  = timer2_control & t2_wmask;
        t2ctl_rd[`STC_T2_TF2]     = timer_overflow_flag[2];
    end

    // read mux, unmapped addresses read zero
    logic [7:0] rd_mux;
    always_comb begin
        case (sfr_addr)
            `STC_ADDR_TCTL:  rd_mux = tctl_rd;
            `STC_ADDR_TMODE: rd_mux = timer_shared_mode;
            `STC_ADDR_T2CTL: rd_mux = t2ctl_rd;
            `STC_ADDR_TL0:   rd_mux = timer0_count_low;
            `STC_ADDR_TH0:   rd_mux = timer0_count_high;
            `STC_ADDR_TL1:   rd_mux = timer1_count_low;
            `STC_ADDR_TH1:   rd_mux = timer1_count_high;
            `STC_ADDR_TL2:   rd_mux = timer2_count_low;
            `STC_ADDR_TH2:   rd_mux = timer2_count_high;
            `STC_ADDR_RCL2:  rd_mux = timer2_capture_reload_low;
            `STC_ADDR_RCH2:  rd_mux = timer2_capture_reload_high;
            default:         rd_mux = 8'h00;
        endcase
    end

    // control and status
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            timer_shared_control <= `STC_TCTL_RST;
            timer_shared_mode    <= `STC_TMODE_RST;
            timer2_control       <= `STC_T2CTL_RST;
            timer_overflow_flag  <= 3'b000;
            sfr_rdata            <= 8'h00;
        end else begin
            if (wr_tctl) begin
                timer_shared_control <= sfr_wdata & tctl_wmask;
            end
            if (wr_tmode) begin
                timer_shared_mode <= sfr_wdata;
            end
            if (wr_t2ctl) begin
                timer2_control <= sfr_wdata & t2_wmask;
            end
            timer_overflow_flag <= next_flag;
            sfr_rdata           <= rd_mux;
        end
    end

    // count registers: software write beats the count step
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            timer0_count_low  <= `STC_CNT_RST;
            timer0_count_high <= `STC_CNT_RST;
            timer1_count_low  <= `STC_CNT_RST;
            timer1_count_high <= `STC_CNT_RST;
        end else begin
            timer0_count_low  <= wr_tl0 ? sfr_wdata : step0.lo;
            timer0_count_high <= wr_th0 ? sfr_wdata : th0_next;
            timer1_count_low  <= wr_tl1 ? sfr_wdata : step1.lo;
            timer1_count_high <= wr_th1 ? sfr_wdata : step1.hi;
        end
    end

    // timer 2 count and capture/reload pair
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            timer2_count_low           <= `STC_CNT_RST;
            timer2_count_high          <= `STC_CNT_RST;
            timer2_capture_reload_low  <= `STC_CNT_RST;
            timer2_capture_reload_high <= `STC_CNT_RST;
        end else begin
            timer2_count_low  <= wr_tl2 ? sfr_wdata : t2_next[7:0];
            timer2_count_high <= wr_th2 ? sfr_wdata : t2_next[15:8];
            if (capture2) begin
                timer2_capture_reload_low  <= timer2_count_low;
                timer2_capture_reload_high <= timer2_count_high;
            end else begin
                if (wr_rcl2) begin
                    timer2_capture_reload_low <= sfr_wdata;
                end
                if (wr_rch2) begin
                    timer2_capture_reload_high <= sfr_wdata;
                end
            end
        end
    end

endmodule

/* tb/stc_top_chk.sv */
`timescale 1ns/1ns
module stc_chk (
    input logic       ref_clk,
    input logic       rst,
    input logic [7:0] sfr_addr,
    input logic       sfr_wr,
    input logic [7:0] sfr_wdata,
    input logic [7:0] sfr_rdata,
    input logic [2:0] overflow_ack,
    input logic [2:0] timer_overflow_flag
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    wire mapped = sfr_addr inside {8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d,
                                   8'hc8, 8'hca, 8'hcb, 8'hcc, 8'hcd};
    wire count_byte = sfr_addr inside {8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'hcc, 8'hcd};

    // write, then a read of the same place
    sequence s_wr_rd(sel);
        sfr_wr && sel ##1 !sfr_wr && $stable(sfr_addr);
    endsequence

    property p_count_readback;
        s_wr_rd(count_byte) |=> sfr_rdata == $past(sfr_wdata, 2);
    endproperty
    a_count_readback: assert property (p_count_readback)
        else $error("count byte readback differs");

    property p_ctl_readback;
        s_wr_rd(sfr_addr == 8'h88) |=> {sfr_rdata[6], sfr_rdata[4], sfr_rdata[3:0]}
            == {$past(sfr_wdata[6], 2), $past(sfr_wdata[4], 2), 4'h0};
    endproperty
    a_ctl_readback: assert property (p_ctl_readback)
        else $error("shared control readback differs");

    property p_mode_readback;
        s_wr_rd(sfr_addr == 8'h89) |=> sfr_rdata == $past(sfr_wdata, 2);
    endproperty
    a_mode_readback: assert property (p_mode_readback)
        else $error("shared mode readback differs");

    property p_cap_readback;
        s_wr_rd(sfr_addr inside {8'hca, 8'hcb}) |=> sfr_rdata == $past(sfr_wdata, 2);
    endproperty
    a_cap_readback: assert property (p_cap_readback)
        else $error("capture pair readback differs");

    property p_tf_view;
        sfr_addr == 8'h88 |=> {sfr_rdata[7], sfr_rdata[5]} == $past(timer_overflow_flag[1:0]);
    endproperty
    a_tf_view: assert property (p_tf_view)
        else $error("flags in shared control differ from flag port");

    property p_t2_view;
        sfr_addr == 8'hc8 |=> sfr_rdata[7] == $past(timer_overflow_flag[2]) && !sfr_rdata[3];
    endproperty
    a_t2_view: assert property (p_t2_view)
        else $error("timer two control read wrong");

    property p_unmapped;
        !mapped |=> sfr_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped address reads nonzero");

    property p_flag_hold;
        !$past(rst) |-> ($past(timer_overflow_flag & ~overflow_ack) & ~timer_overflow_flag)
            == 3'h0;
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("flag dropped without service");

    property p_rst_clear;
        disable iff (1'b0) rst |=> sfr_rdata == 8'h00 && timer_overflow_flag == 3'h0;
    endproperty
    a_rst_clear: assert property (p_rst_clear)
        else $error("reset left state set");

    c_flag_two: cover property ($rose(timer_overflow_flag[2]));
    c_ack: cover property (|(overflow_ack & timer_overflow_flag));
    c_ctl: cover property (s_wr_rd(sfr_addr == 8'h88));
endmodule

bind stc_top stc_chk u_chk (
    .ref_clk(ref_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .overflow_ack(overflow_ack),
    .timer_overflow_flag(timer_overflow_flag)
);

/* tb/stc_pulse_src.sv */
`timescale 1ns/1ns
module stc_pulse_src (
    input  logic       ref_clk,
    output logic [2:0] pins
);
    initial pins = 3'b111;

    // each level held a sample period
    task automatic burst(input logic [2:0] sel, input int n, input int half);
        repeat (n) begin
            @(negedge ref_clk);
            pins = pins & ~sel;
            repeat (half) @(negedge ref_clk);
            pins = pins | sel;
            repeat (half - 1) @(negedge ref_clk);
        end
    endtask
endmodule

/* tb/standard_timer_counter_clocking_bench.sv */
`timescale 1ns/1ns
module standard_timer_counter_clocking_bench;
    logic       ref_clk;
    logic       rst;
    logic [7:0] sfr_addr;
    logic       sfr_wr;
    logic [7:0] sfr_wdata;
    logic [7:0] sfr_rdata;
    logic [2:0] cpu_div;
    logic [1:0] ext_int;
    logic [2:0] ack;
    logic [2:0] flag;
    logic [2:0] pins;
    logic [7:0] v;
    int         num_errors;
    int         compares;
    int         n;
    logic [7:0] regs [11] = '{8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d,
                              8'hc8, 8'hca, 8'hcb, 8'hcc, 8'hcd};
    logic [7:0] cnts [6]  = '{8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'hcc, 8'hcd};
    logic [7:0] lows [3]  = '{8'h8a, 8'h8b, 8'hcc};

    stc_pulse_src src (.ref_clk(ref_clk), .pins(pins));

    stc_top dut (
        .ref_clk(ref_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .cpu_clock_divider_config(cpu_div),
        .timer_zero_event_pin(pins[0]), .timer_one_event_pin(pins[1]),
        .timer_two_event_pin(pins[2]), .external_interrupt_pin(ext_int),
        .overflow_ack(ack), .timer_overflow_flag(flag)
    );

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge ref_clk);
        sfr_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(negedge ref_clk);
        sfr_addr = a;
        @(negedge ref_clk);
        v = sfr_rdata;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        rd(a);
        chk(v, e);
    endtask

    // cycles between two changes of the low count byte
    task automatic period();
        logic [7:0] last;
        rd(8'h8a);
        repeat (2) begin
            last = sfr_rdata;
            n = 0;
            while (sfr_rdata === last && n < 40) begin
                @(negedge ref_clk);
                n++;
            end
        end
    endtask

    task automatic service(input logic [2:0] m);
        @(negedge ref_clk);
        ack = m;
        @(negedge ref_clk);
        ack = 3'h0;
        @(negedge ref_clk);
        chk({5'h00, flag & m}, 8'h00);
    endtask

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        tally_and_finish();
    end

    initial begin
        rst = 1'b1;
        sfr_addr = 8'h00;
        sfr_wr = 1'b0;
        sfr_wdata = 8'h00;
        cpu_div = 3'h0;
        ext_int = 2'h0;
        ack = 3'h0;
        repeat (20) @(negedge ref_clk);
        rst = 1'b0;

        foreach (regs[i]) rdchk(regs[i], 8'h00);
        wr(8'h90, 8'h5a);
        rdchk(8'h90, 8'h00);
        wr(8'h89, 8'h5a);
        rdchk(8'h89, 8'h5a);
        $display("test registers done");

        wr(8'h89, 8'h01);
        wr(8'h88, 8'h10);
        for (int d = 0; d < 6; d += 5) begin
            cpu_div = 3'(d);
            period();
            chk(8'(n), 8'h0c);
        end
        cpu_div = 3'h0;
        $display("test timer rate done");

        wr(8'h88, 8'h00);
        wr(8'h89, 8'h55);
        foreach (cnts[i]) wr(cnts[i], 8'h00);
        wr(8'h88, 8'h50);
        wr(8'hc8, 8'h07);
        src.burst(3'b111, 5, 12);
        repeat (60) @(negedge ref_clk);
        foreach (lows[i]) rdchk(lows[i], 8'h05);
        cpu_div = 3'h1;
        src.burst(3'b111, 5, 24);
        repeat (100) @(negedge ref_clk);
        foreach (lows[i]) rdchk(lows[i], 8'h0a);
        cpu_div = 3'h0;
        wr(8'h88, 8'h00);
        wr(8'hc8, 8'h00);
        $display("test event counting done");

        wr(8'h89, 8'h09);
        wr(8'h8a, 8'h00);
        wr(8'h88, 8'h10);
        repeat (60) @(negedge ref_clk);
        rdchk(8'h8a, 8'h00);
        ext_int = 2'h1;
        repeat (60) @(negedge ref_clk);
        rd(8'h8a);
        chk({7'h00, v != 8'h00}, 8'h01);
        ext_int = 2'h0;
        wr(8'h88, 8'h00);
        $display("test gate done");

        wr(8'h89, 8'h11);
        foreach (cnts[i]) wr(cnts[i], 8'hff);
        wr(8'hcb, 8'h12);
        wr(8'hca, 8'h34);
        rdchk(8'hca, 8'h34);
        wr(8'h88, 8'h50);
        wr(8'hc8, 8'h04);
        repeat (20) @(negedge ref_clk);
        wr(8'h88, 8'h00);
        wr(8'hc8, 8'h00);
        chk({5'h00, flag}, 8'h07);
        rdchk(8'h88, 8'ha0);
        rdchk(8'h8c, 8'h00);
        rdchk(8'hcd, 8'h12);
        service(3'b111);
        wr(8'hc8, 8'h08);
        rdchk(8'hcb, 8'h12);
        rdchk(8'hc8, 8'h00);
        $display("test overflow done");

        wr(8'h89, 8'h02);
        wr(8'h8c, 8'hf0);
        wr(8'h8a, 8'hff);
        wr(8'h88, 8'h10);
        repeat (14) @(negedge ref_clk);
        wr(8'h88, 8'h00);
        rdchk(8'h8c, 8'hf0);
        rd(8'h8a);
        chk({7'h00, v inside {8'hf0, 8'hf1}}, 8'h01);
        chk({7'h00, flag[0]}, 8'h01);
        service(3'b001);
        $display("test reload done");
        tally_and_finish();
    end
endmodule
